// File: tb_top.sv
// Self-checking bench for the list scheduler.
// Assumes a 400-cycle frame and shared area at address zero.
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, run = 1'b0, ctrl_en = 1'b0, per_en = 1'b0;
  logic [2:0]  port_on = 3'h5, pmask;
  logic [31:0] chead = 32'h0;
  logic        mreq, mwr, mack, sof, treq, tdone, tls, ben, tiso, ttog;
  logic [1:0]  tdir;
  logic [31:0] maddr, mwdata, mrdata, tbuf;
  logic [15:0] fnum;
  logic [10:0] tlen, tbytes;
  logic [6:0]  tfa;
  logic [3:0]  tep;
  logic [31:0] img [12] = '{32'h0008_0105, 32'h160, 32'h140, 32'h0, 32'hF008_0000, 32'h200,
    32'h180, 32'h207, 32'hF008_0000, 32'h300, 32'h160, 32'h303};
  int          miscompares = 0, check_count = 0;
  usbls_sched #(.FRAME_CYCLES(400)) DUT (.CLK_IN(clk), .RST_IN(rst), .RUN_IN(run),
    .CTRL_EN_IN(ctrl_en), .BULK_EN_IN(ctrl_en), .PER_EN_IN(per_en), .CB_RATIO_IN(2'h0),
    .HCCA_BASE_IN(32'h0), .CTRL_HEAD_IN(chead), .BULK_HEAD_IN(32'h0), .PER_START_IN(14'h012C),
    .PORT_ON_IN(port_on), .MEM_ACK_IN(mack), .MEM_RDATA_IN(mrdata), .TXN_DONE_IN(tdone),
    .TXN_CC_IN(4'h0), .TXN_BYTES_IN(tbytes), .MEM_REQ_OUT(mreq), .MEM_WR_OUT(mwr),
    .MEM_ADDR_OUT(maddr), .MEM_WDATA_OUT(mwdata), .SOF_OUT(sof), .FRAME_NUM_OUT(fnum),
    .BIT_EN_OUT(ben), .PORT_MASK_OUT(pmask), .TXN_REQ_OUT(treq), .TXN_FADDR_OUT(tfa),
    .TXN_EP_OUT(tep), .TXN_DIR_OUT(tdir), .TXN_LS_OUT(tls), .TXN_ISO_OUT(tiso),
    .TXN_TOGGLE_OUT(ttog),
    .TXN_BUF_OUT(tbuf), .TXN_LEN_OUT(tlen));
  usbls_far_model PM (.clk_in(clk), .rst_in(rst), .mem_req_in(mreq), .mem_wr_in(mwr),
    .mem_addr_in(maddr), .mem_wdata_in(mwdata), .txn_req_in(treq), .txn_len_in(tlen),
    .mem_ack_out(mack), .mem_rdata_out(mrdata), .txn_done_out(tdone), .txn_bytes_out(tbytes));
  initial forever #4 clk = ~clk;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_for(input bit on_sof, input logic lvl);
    int n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((on_sof ? sof : treq) !== lvl && n < 3000);
    if ((on_sof ? sof : treq) !== lvl) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task t_frames();
    int n_en;
    n_en = 0;
    repeat (3) wait_for(1'b1, 1'b1);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      n_en += ben;
    end
    check_count++;
    if (n_en < 19 || n_en > 20) begin
      miscompares++;
      $display("mismatch bit enables expected 19 seen %0d", n_en);
    end
    chk("frame number", 32'h0000_0003, 32'(fnum));
    chk("frame word", 32'h0000_0003, PM.mem[32]);
    chk("own head read", 32'h1, 32'(PM.hit[3]));
    chk("next head read", 32'h0, 32'(PM.hit[4]));
    chk("port mask", 32'(port_on), 32'(pmask));
  endtask
  task t_ctrl_list();
    @(posedge clk);
    chead <= 32'h0000_0100;
    ctrl_en <= 1'b1;
    wait_for(1'b0, 1'b1);
    chk("first buffer", 32'h0000_0200, tbuf);
    chk("first length", 32'h0000_0008, 32'(tlen));
    chk("target", 32'h0000_00A4, 32'({tfa, tep, tls}));
    chk("first flags", 32'h0000_0004, 32'({tdir, tiso, ttog}));
    wait_for(1'b0, 1'b0);
    wait_for(1'b0, 1'b1);
    chk("second buffer", 32'h0000_0300, tbuf);
    chk("second length", 32'h0000_0004, 32'(tlen));
    chk("second flags", 32'h0000_0005, 32'({tdir, tiso, ttog}));
    repeat (2) wait_for(1'b1, 1'b1);
    repeat (30) @(posedge clk);
    chk("done head", 32'h0000_0180, PM.mem[33]);
    chk("done link", 32'h0000_0140, PM.mem[98]);
    chk("first link", 32'h0, PM.mem[82]);
    chk("queue head", 32'h0000_0160, PM.mem[66] & 32'hFFFF_FFF0);
  endtask
  initial begin
    for (int i = 0; i < 1024; i++) PM.mem[i] = 32'h0;
    for (int i = 0; i < 4; i++) begin
      PM.mem[64 + i] = img[i];
      PM.mem[80 + i] = img[4 + i];
      PM.mem[96 + i] = img[8 + i];
    end
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("idle outputs", 32'h0, 32'({mreq, sof, treq, fnum}));
    @(posedge clk);
    run <= 1'b1;
    per_en <= 1'b1;
    port_on <= 3'h3;
    t_frames();
    t_ctrl_list();
    end_of_test();
  end
endmodule

// File: usbls_far_model.sv
// Shared memory and serial engine standing in for the far side.
// Assumes word addresses below 4 KiB on the scheduler's clock.
`timescale 1ns/100ps
module usbls_far_model (
  input  logic        clk_in,
  input  logic        rst_in,
  input  logic        mem_req_in,
  input  logic        mem_wr_in,
  input  logic [31:0] mem_addr_in,
  input  logic [31:0] mem_wdata_in,
  input  logic        txn_req_in,
  input  logic [10:0] txn_len_in,
  output logic        mem_ack_out,
  output logic [31:0] mem_rdata_out,
  output logic        txn_done_out,
  output logic [10:0] txn_bytes_out
);
  logic [31:0] mem [0:1023];
  logic [31:0] hit;
  logic [1:0]  wait_ff;
  logic        slow_ff;
  logic [2:0]  link_ff;
  // After the first ack, acks alternate between prompt and two cycles late
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= 32'h0;
      hit <= 32'h0;
      wait_ff <= 2'h0;
      slow_ff <= 1'b0;
    end else begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      if (mem_req_in && !mem_ack_out && wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else if (mem_req_in && !mem_ack_out) begin
        mem_ack_out <= 1'b1;
        slow_ff <= ~slow_ff;
        wait_ff <= {slow_ff, 1'b0};
        mem_rdata_out <= mem[mem_addr_in[11:2]];
        if (mem_wr_in) mem[mem_addr_in[11:2]] <= mem_wdata_in;
        else if (mem_addr_in < 32'h80) hit[mem_addr_in[6:2]] <= 1'b1;
      end
    end
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      txn_done_out <= 1'b0;
      txn_bytes_out <= 11'h0;
      link_ff <= 3'h0;
    end else begin
      txn_done_out <= 1'b0;
      txn_bytes_out <= ~txn_bytes_out;
      link_ff <= 3'h0;
      if (txn_req_in && !txn_done_out && link_ff != 3'h5) link_ff <= link_ff + 3'h1;
      else if (txn_req_in && !txn_done_out) begin
        txn_done_out <= 1'b1;
        txn_bytes_out <= txn_len_in;
      end
    end
  end
endmodule

// File: usbls_frame_if.sv
// Frame timing signals between the frame timer and the list scheduler.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface usbls_frame_if;
  logic        run;
  logic [13:0] per_start;
  logic        sof;
  logic        periodic_due;
  logic        fs_tick;
  logic        ls_tick;
  logic [15:0] frame_num;
  modport timer (input run, per_start, output sof, periodic_due, fs_tick, ls_tick, frame_num);
  modport sched (output run, per_start, input sof, periodic_due, fs_tick, ls_tick, frame_num);
endinterface

// File: usbls_frame_timer.sv
// Frame interval counter, frame number and bit-rate enables.
// Assumes run and per_start come from logic on the same clock.
`timescale 1ns/100ps
module usbls_frame_timer #(
  parameter int FRAME_CYCLES = usbls_pkg::FRAME_CYC
) (
  input  wire logic      clk_in,
  input  wire logic      rst_in,
  usbls_frame_if.timer   fi
);

  logic [16:0] remain_ff;
  logic [23:0] fs_acc_ff;
  logic [23:0] ls_acc_ff;
  logic [24:0] fs_sum;
  logic [24:0] ls_sum;

  assign fs_sum = {1'b0, fs_acc_ff} + {1'b0, usbls_pkg::FS_STEP};
  assign ls_sum = {1'b0, ls_acc_ff} + {1'b0, usbls_pkg::LS_STEP};

  // ----------------------------------------------------------------
  // Frame interval: SOF pulse and frame number step at wrap
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      remain_ff       <= 17'h00000;
      fi.sof          <= 1'b0;
      fi.frame_num    <= 16'h0000;
      fi.periodic_due <= 1'b0;
    end else if (!fi.run) begin
      remain_ff       <= 17'h00000;
      fi.sof          <= 1'b0;
      fi.periodic_due <= 1'b0;
    end else begin
      fi.sof          <= (remain_ff == 17'h00000);
      fi.periodic_due <= (remain_ff <= {3'h0, fi.per_start});
      if (remain_ff == 17'h00000) begin
        remain_ff    <= 17'(FRAME_CYCLES - 1);
        fi.frame_num <= fi.frame_num + 16'h0001;
      end else begin
        remain_ff <= remain_ff - 17'h00001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Full-speed and low-speed bit enables from phase accumulators
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fs_acc_ff  <= 24'h000000;
      ls_acc_ff  <= 24'h000000;
      fi.fs_tick <= 1'b0;
      fi.ls_tick <= 1'b0;
    end else begin
      fs_acc_ff  <= fs_sum[23:0];
      ls_acc_ff  <= ls_sum[23:0];
      fi.fs_tick <= fs_sum[24];
      fi.ls_tick <= ls_sum[24];
    end
  end

endmodule

// File: usbls_pkg.sv
// Constants, field layouts and state codes for the USB list scheduler.
// Assumes a single 125 MHz system clock shared by every module of the block.
package usbls_pkg;

  // ----------------------------------------------------------------
  // Clock, frame and signalling rates
  // ----------------------------------------------------------------
  localparam int          CLK_HZ     = 125_000_000;
  localparam int          FRAME_US   = 1000;
  localparam int          FRAME_CYC  = (CLK_HZ / 1_000_000) * FRAME_US;
  localparam int          FS_BPS     = 12_000_000;
  localparam int          LS_BPS     = 1_200_000;
  localparam int          ACC_W      = 24;
  localparam logic [23:0] FS_STEP    = 24'((longint'(FS_BPS) << ACC_W) / CLK_HZ);
  localparam logic [23:0] LS_STEP    = 24'((longint'(LS_BPS) << ACC_W) / CLK_HZ);

  // ----------------------------------------------------------------
  // Root hub and shared area
  // ----------------------------------------------------------------
  localparam int          NUM_PORTS  = 3;
  localparam int          IDX_W      = 5;
  localparam logic [31:0] HCCA_FRNUM = 32'h0000_0080;
  localparam logic [31:0] HCCA_DONE  = 32'h0000_0084;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] TD_NEXT_OF = 32'h0000_0008;
  localparam logic [31:0] TD_CBP_OF  = 32'h0000_0004;
  localparam logic [31:0] ED_HEAD_OF = 32'h0000_0008;
  localparam logic [31:0] PTR_MASK   = 32'hFFFF_FFF0;

  // ----------------------------------------------------------------
  // Descriptor field positions
  // ----------------------------------------------------------------
  localparam int          ED_FA_LSB  = 0;
  localparam int          ED_EN_LSB  = 7;
  localparam int          ED_D_LSB   = 11;
  localparam int          ED_S_BIT   = 13;
  localparam int          ED_K_BIT   = 14;
  localparam int          ED_F_BIT   = 15;
  localparam int          ED_MPS_LSB = 16;
  localparam int          ED_H_BIT   = 0;
  localparam int          ED_C_BIT   = 1;
  localparam int          TD_DP_LSB  = 19;
  localparam int          TD_T_LSB   = 24;
  localparam int          TD_CC_LSB  = 28;
  localparam logic [3:0]  CC_NOERR   = 4'h0;
  localparam logic [13:0] PAGE_BYTES = 14'h1000;

  // ----------------------------------------------------------------
  // Scheduler states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE   = 4'h0, S_SOF    = 4'h1, S_FNW    = 4'h2, S_DHW    = 4'h3,
    S_NPSEL  = 4'h4, S_PHEAD  = 4'h5, S_EDRD   = 4'h6, S_EDCHK  = 4'h7,
    S_TDRD   = 4'h8, S_TXN    = 4'h9, S_TXWAIT = 4'hA, S_TDWB0  = 4'hB,
    S_TDWB1  = 4'hC, S_TDLINK = 4'hD, S_EDWB   = 4'hE, S_NEXT   = 4'hF
  } usbls_state_t;

endpackage

// File: usbls_properties.sv
// Port assertions for the list scheduler.
// Assumes binding to usbls_sched and its one-cycle handshakes.
`timescale 1ns/100ps
module usbls_chk (
  input logic        CLK_IN,
  input logic        RST_IN,
  input logic [2:0]  PORT_ON_IN,
  input logic [31:0] HCCA_BASE_IN,
  input logic        MEM_ACK_IN,
  input logic        TXN_DONE_IN,
  input logic        MEM_REQ_OUT,
  input logic        MEM_WR_OUT,
  input logic [31:0] MEM_ADDR_OUT,
  input logic [31:0] MEM_WDATA_OUT,
  input logic        SOF_OUT,
  input logic [15:0] FRAME_NUM_OUT,
  input logic [2:0]  PORT_MASK_OUT,
  input logic        TXN_REQ_OUT,
  input logic [10:0] TXN_LEN_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_fn_write;
    MEM_REQ_OUT && MEM_WR_OUT && MEM_ADDR_OUT == HCCA_BASE_IN + 32'h0000_0080
      && MEM_WDATA_OUT == {16'h0000, FRAME_NUM_OUT};
  endsequence
  sequence s_ports_still;
    $stable(PORT_ON_IN) [*4];
  endsequence
  a_mem_hold: assert property (
    MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT) && $stable(MEM_WDATA_OUT))
    else $error("memory request moved before ack");
  a_mem_drop: assert property (
    MEM_REQ_OUT && MEM_ACK_IN |=> !MEM_REQ_OUT) else $error("memory request kept after ack");
  a_sof_alone: assert property (
    SOF_OUT |-> !TXN_REQ_OUT ##1 (!SOF_OUT) [*8]) else $error("frame start overlaps traffic");
  a_frame_step: assert property (
    $changed(FRAME_NUM_OUT) |-> FRAME_NUM_OUT == $past(FRAME_NUM_OUT) + 16'h0001)
    else $error("frame number jumped");
  a_fn_write: assert property (
    SOF_OUT |-> ##[1:8] s_fn_write) else $error("frame number not stored");
  a_txn_hold: assert property (
    TXN_REQ_OUT && !TXN_DONE_IN |=> TXN_REQ_OUT && $stable(TXN_LEN_OUT))
    else $error("transaction moved before done");
  a_txn_drop: assert property (
    TXN_REQ_OUT && TXN_DONE_IN |=> !TXN_REQ_OUT) else $error("transaction kept after done");
  a_port_sync: assert property (
    s_ports_still |-> PORT_MASK_OUT == PORT_ON_IN) else $error("port mask lags");
endmodule
bind usbls_sched usbls_chk u_chk (.*);

// File: usbls_sched.sv
// List scheduler: frame sequencing, descriptor walk and done queue.
// Assumes a word memory master that answers MEM_REQ_OUT with a one-cycle MEM_ACK_IN,
// and a serial engine that answers TXN_REQ_OUT with a one-cycle TXN_DONE_IN.
// Function
// - Serve low-speed and full-speed bit rates.
// - Three root hub downstream ports.
// - Operational settings are inputs only, never master.
// - Master all accesses to shared area.
// - Take fields from ED, follow next link.
// - Handle 0-8192 byte buffers, one page crossing.
// - Serve endpoint TDs oldest first.
// - Control and bulk heads held locally.
// - Isochronous EDs reached via interrupt list tail.
// - Interrupt head chosen by frame low 5 bits.
// - Periodic every frame, nonperiodic as time allows.
// - Frames last 1.0 ms.
// - SOF first in every frame.
// - Nonperiodic until threshold, then periodic.
// - After periodic, nonperiodic fills remainder.
// - Write frame number to shared area each frame.
// - Retired TD goes to done queue head.
// - n control per one bulk, resuming lists.
`timescale 1ns/100ps
module usbls_sched #(
  parameter int FRAME_CYCLES = usbls_pkg::FRAME_CYC
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        RUN_IN,
  input  wire logic        CTRL_EN_IN,
  input  wire logic        BULK_EN_IN,
  input  wire logic        PER_EN_IN,
  input  wire logic [1:0]  CB_RATIO_IN,
  input  wire logic [31:0] HCCA_BASE_IN,
  input  wire logic [31:0] CTRL_HEAD_IN,
  input  wire logic [31:0] BULK_HEAD_IN,
  input  wire logic [13:0] PER_START_IN,
  input  wire logic [2:0]  PORT_ON_IN,
  input  wire logic        MEM_ACK_IN,
  input  wire logic [31:0] MEM_RDATA_IN,
  input  wire logic        TXN_DONE_IN,
  input  wire logic [3:0]  TXN_CC_IN,
  input  wire logic [10:0] TXN_BYTES_IN,
  output logic             MEM_REQ_OUT,
  output logic             MEM_WR_OUT,
  output logic [31:0]      MEM_ADDR_OUT,
  output logic [31:0]      MEM_WDATA_OUT,
  output logic             SOF_OUT,
  output logic [15:0]      FRAME_NUM_OUT,
  output logic             BIT_EN_OUT,
  output logic [2:0]       PORT_MASK_OUT,
  output logic             TXN_REQ_OUT,
  output logic [6:0]       TXN_FADDR_OUT,
  output logic [3:0]       TXN_EP_OUT,
  output logic [1:0]       TXN_DIR_OUT,
  output logic             TXN_LS_OUT,
  output logic             TXN_ISO_OUT,
  output logic             TXN_TOGGLE_OUT,
  output logic [31:0]      TXN_BUF_OUT,
  output logic [10:0]      TXN_LEN_OUT
);

  usbls_frame_if fi ();
  usbls_pkg::usbls_state_t state_ff;
  logic [31:0] ed_w [0:3];
  logic [31:0] td_w [0:3];
  logic [1:0]  wcnt_ff;
  logic [31:0] ed_ptr_ff, td_ptr_ff, done_head_ff, ctrl_cur_ff, bulk_cur_ff;
  logic        per_ff, per_done_ff, sof_pend_ff, sel_ctrl_ff, retire_ff, tog_ff;
  logic [3:0]  cc_ff;
  logic [2:0]  cb_cnt_ff;
  logic [31:0] cbp_ff;
  logic [2:0]  port_s1_ff, port_s2_ff;
  logic [31:0] nxt_addr, nxt_wdata, ctrl_ptr, bulk_ptr, cbp, be, ed_next;
  logic        nxt_wr, use_ctrl, tog, ed_skip;
  logic [13:0] buf_len, pkt, sum;
  logic [10:0] mps;

  usbls_frame_timer #(.FRAME_CYCLES(FRAME_CYCLES)) u_timer (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .fi     (fi)
  );

  assign fi.run        = RUN_IN;
  assign fi.per_start  = PER_START_IN;
  assign FRAME_NUM_OUT = fi.frame_num;

  // ----------------------------------------------------------------
  // Port enable pins, three-stage synchronisers
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < usbls_pkg::NUM_PORTS; gp++) begin : g_port
      always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          port_s1_ff[gp]    <= 1'b0;
          port_s2_ff[gp]    <= 1'b0;
          PORT_MASK_OUT[gp] <= 1'b0;
        end else begin
          port_s1_ff[gp]    <= PORT_ON_IN[gp];
          port_s2_ff[gp]    <= port_s1_ff[gp];
          PORT_MASK_OUT[gp] <= port_s2_ff[gp];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Descriptor decode
  // ----------------------------------------------------------------
  assign cbp      = td_w[1];
  assign be       = td_w[3];
  assign mps      = ed_w[0][usbls_pkg::ED_MPS_LSB +: 11];
  assign ed_next  = ed_w[3] & usbls_pkg::PTR_MASK;
  assign ctrl_ptr = (ctrl_cur_ff == 32'h0) ? CTRL_HEAD_IN : ctrl_cur_ff;
  assign bulk_ptr = (bulk_cur_ff == 32'h0) ? BULK_HEAD_IN : bulk_cur_ff;
  assign use_ctrl = CTRL_EN_IN && (ctrl_ptr != 32'h0) &&
                    ((cb_cnt_ff <= {1'b0, CB_RATIO_IN}) || !BULK_EN_IN ||
                     (bulk_ptr == 32'h0));
  assign tog      = td_w[0][usbls_pkg::TD_T_LSB + 1] ? td_w[0][usbls_pkg::TD_T_LSB]
                                                     : ed_w[2][usbls_pkg::ED_C_BIT];
  assign ed_skip  = ed_w[0][usbls_pkg::ED_K_BIT] || ed_w[2][usbls_pkg::ED_H_BIT] ||
                    ((ed_w[2] & usbls_pkg::PTR_MASK) == (ed_w[1] & usbls_pkg::PTR_MASK));
  assign sum      = {2'b00, cbp_ff[11:0]} + {3'b000, TXN_BYTES_IN};

  // Buffer span, at most one page crossing
  always_comb begin
    if (cbp == 32'h0) begin
      buf_len = 14'h0000;
    end else if (cbp[31:12] == be[31:12]) begin
      buf_len = {2'b00, be[11:0]} - {2'b00, cbp[11:0]} + 14'h0001;
    end else begin
      buf_len = usbls_pkg::PAGE_BYTES - {2'b00, cbp[11:0]} + {2'b00, be[11:0]} + 14'h0001;
    end
    pkt = (buf_len > {3'b000, mps}) ? {3'b000, mps} : buf_len;
  end

  // ----------------------------------------------------------------
  // Memory request per state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_wr    = 1'b0;
    nxt_addr  = 32'h0;
    nxt_wdata = 32'h0;
    unique case (state_ff)
      usbls_pkg::S_FNW: begin
        nxt_wr    = 1'b1;
        nxt_addr  = HCCA_BASE_IN + usbls_pkg::HCCA_FRNUM;
        nxt_wdata = {16'h0000, fi.frame_num};
      end
      usbls_pkg::S_DHW: begin
        nxt_wr    = 1'b1;
        nxt_addr  = HCCA_BASE_IN + usbls_pkg::HCCA_DONE;
        nxt_wdata = done_head_ff;
      end
      usbls_pkg::S_PHEAD: nxt_addr = HCCA_BASE_IN + {25'h0, fi.frame_num[4:0], 2'b00};
      usbls_pkg::S_EDRD:  nxt_addr = ed_ptr_ff + {28'h0, wcnt_ff, 2'b00};
      usbls_pkg::S_TDRD:  nxt_addr = td_ptr_ff + {28'h0, wcnt_ff, 2'b00};
      usbls_pkg::S_TDWB0: begin
        nxt_wr    = 1'b1;
        nxt_addr  = td_ptr_ff;
        nxt_wdata = {cc_ff, td_w[0][27:26], 1'b1, tog_ff, td_w[0][23:0]};
      end
      usbls_pkg::S_TDWB1: begin
        nxt_wr    = 1'b1;
        nxt_addr  = td_ptr_ff + usbls_pkg::TD_CBP_OF;
        nxt_wdata = cbp_ff;
      end
      usbls_pkg::S_TDLINK: begin
        nxt_wr    = 1'b1;
        nxt_addr  = td_ptr_ff + usbls_pkg::TD_NEXT_OF;
        nxt_wdata = done_head_ff;
      end
      usbls_pkg::S_EDWB: begin
        nxt_wr    = 1'b1;
        nxt_addr  = ed_ptr_ff + usbls_pkg::ED_HEAD_OF;
        nxt_wdata = (td_w[2] & usbls_pkg::PTR_MASK) |
                    {30'h0, tog_ff, (cc_ff != usbls_pkg::CC_NOERR)};
      end
      default: ;
    endcase
  end

  // ----------------------------------------------------------------
  // Scheduler sequence and memory bus
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_ff <= usbls_pkg::S_IDLE;
      MEM_REQ_OUT <= 1'b0;
      MEM_WR_OUT <= 1'b0;
      MEM_ADDR_OUT <= 32'h0;
      MEM_WDATA_OUT <= 32'h0;
      SOF_OUT <= 1'b0;
      TXN_REQ_OUT <= 1'b0;
      TXN_FADDR_OUT <= 7'h00;
      TXN_EP_OUT <= 4'h0;
      TXN_DIR_OUT <= 2'h0;
      TXN_LS_OUT <= 1'b0;
      TXN_ISO_OUT <= 1'b0;
      TXN_TOGGLE_OUT <= 1'b0;
      TXN_BUF_OUT <= 32'h0;
      TXN_LEN_OUT <= 11'h000;
      for (int i = 0; i < 4; i++) begin
        ed_w[i] <= 32'h0;
        td_w[i] <= 32'h0;
      end
      wcnt_ff <= 2'h0;
      ed_ptr_ff <= 32'h0;
      td_ptr_ff <= 32'h0;
      done_head_ff <= 32'h0;
      ctrl_cur_ff <= 32'h0;
      bulk_cur_ff <= 32'h0;
      per_ff <= 1'b0;
      per_done_ff <= 1'b0;
      sof_pend_ff <= 1'b0;
      sel_ctrl_ff <= 1'b0;
      retire_ff <= 1'b0;
      tog_ff <= 1'b0;
      cc_ff <= 4'h0;
      cb_cnt_ff <= 3'h0;
      cbp_ff <= 32'h0;
    end else begin
      SOF_OUT <= 1'b0;
      if (fi.sof) begin
        sof_pend_ff <= 1'b1;
      end else if (state_ff == usbls_pkg::S_SOF) begin
        sof_pend_ff <= 1'b0;
      end
      if (nxt_wr || state_ff inside {usbls_pkg::S_PHEAD, usbls_pkg::S_EDRD,
                                     usbls_pkg::S_TDRD}) begin
        if (!MEM_REQ_OUT) begin
          MEM_REQ_OUT <= 1'b1;
          MEM_WR_OUT <= nxt_wr;
          MEM_ADDR_OUT <= nxt_addr;
          MEM_WDATA_OUT <= nxt_wdata;
        end else if (MEM_ACK_IN) begin
          MEM_REQ_OUT <= 1'b0;
        end
      end
      unique case (state_ff)
        usbls_pkg::S_IDLE: if (RUN_IN && fi.sof) state_ff <= usbls_pkg::S_SOF;
        usbls_pkg::S_SOF: begin
          SOF_OUT <= 1'b1;
          per_done_ff <= !PER_EN_IN;
          state_ff <= usbls_pkg::S_FNW;
        end
        usbls_pkg::S_FNW: if (MEM_REQ_OUT && MEM_ACK_IN) state_ff <= usbls_pkg::S_DHW;
        usbls_pkg::S_DHW: if (MEM_REQ_OUT && MEM_ACK_IN) state_ff <= usbls_pkg::S_NPSEL;
        usbls_pkg::S_NPSEL: begin
          if (!RUN_IN) begin
            state_ff <= usbls_pkg::S_IDLE;
          end else if (sof_pend_ff) begin
            state_ff <= usbls_pkg::S_SOF;
          end else if (fi.periodic_due && !per_done_ff) begin
            per_ff <= 1'b1;
            state_ff <= usbls_pkg::S_PHEAD;
          end else if (use_ctrl) begin
            per_ff <= 1'b0;
            sel_ctrl_ff <= 1'b1;
            ed_ptr_ff <= ctrl_ptr;
            cb_cnt_ff <= cb_cnt_ff + 3'h1;
            state_ff <= usbls_pkg::S_EDRD;
          end else if (BULK_EN_IN && bulk_ptr != 32'h0) begin
            per_ff <= 1'b0;
            sel_ctrl_ff <= 1'b0;
            ed_ptr_ff <= bulk_ptr;
            cb_cnt_ff <= 3'h0;
            state_ff <= usbls_pkg::S_EDRD;
          end
        end
        usbls_pkg::S_PHEAD: if (MEM_REQ_OUT && MEM_ACK_IN) begin
          ed_ptr_ff <= MEM_RDATA_IN & usbls_pkg::PTR_MASK;
          if ((MEM_RDATA_IN & usbls_pkg::PTR_MASK) == 32'h0) begin
            per_done_ff <= 1'b1;
            state_ff <= usbls_pkg::S_NPSEL;
          end else begin
            state_ff <= usbls_pkg::S_EDRD;
          end
        end
        usbls_pkg::S_EDRD, usbls_pkg::S_TDRD: if (MEM_REQ_OUT && MEM_ACK_IN) begin
          if (state_ff == usbls_pkg::S_EDRD) ed_w[wcnt_ff] <= MEM_RDATA_IN;
          else td_w[wcnt_ff] <= MEM_RDATA_IN;
          wcnt_ff <= wcnt_ff + 2'h1;
          if (wcnt_ff == 2'h3) begin
            state_ff <= (state_ff == usbls_pkg::S_EDRD) ? usbls_pkg::S_EDCHK
                                                        : usbls_pkg::S_TXN;
          end
        end
        usbls_pkg::S_EDCHK: begin
          td_ptr_ff <= ed_w[2] & usbls_pkg::PTR_MASK;
          state_ff <= ed_skip ? usbls_pkg::S_NEXT : usbls_pkg::S_TDRD;
        end
        usbls_pkg::S_TXN: begin
          TXN_REQ_OUT <= 1'b1;
          TXN_FADDR_OUT <= ed_w[0][usbls_pkg::ED_FA_LSB +: 7];
          TXN_EP_OUT <= ed_w[0][usbls_pkg::ED_EN_LSB +: 4];
          TXN_DIR_OUT <= (ed_w[0][12] ^ ed_w[0][11]) ? ed_w[0][usbls_pkg::ED_D_LSB +: 2]
                                                     : td_w[0][usbls_pkg::TD_DP_LSB +: 2];
          TXN_LS_OUT <= ed_w[0][usbls_pkg::ED_S_BIT];
          TXN_ISO_OUT <= ed_w[0][usbls_pkg::ED_F_BIT];
          TXN_TOGGLE_OUT <= tog;
          TXN_BUF_OUT <= cbp;
          TXN_LEN_OUT <= pkt[10:0];
          cbp_ff <= cbp;
          state_ff <= usbls_pkg::S_TXWAIT;
        end
        usbls_pkg::S_TXWAIT: if (TXN_DONE_IN) begin
          TXN_REQ_OUT <= 1'b0;
          cc_ff <= TXN_CC_IN;
          tog_ff <= (TXN_CC_IN == usbls_pkg::CC_NOERR) ? !tog : tog;
          retire_ff <= (TXN_CC_IN != usbls_pkg::CC_NOERR) ||
                       ({3'b000, TXN_BYTES_IN} != pkt) ||
                       ({3'b000, TXN_BYTES_IN} == buf_len);
          if ({3'b000, TXN_BYTES_IN} == buf_len) cbp_ff <= 32'h0;
          else if (sum[12]) cbp_ff <= {be[31:12], sum[11:0]};
          else cbp_ff <= {cbp_ff[31:12], sum[11:0]};
          state_ff <= usbls_pkg::S_TDWB0;
        end
        usbls_pkg::S_TDWB0: if (MEM_REQ_OUT && MEM_ACK_IN) state_ff <= usbls_pkg::S_TDWB1;
        usbls_pkg::S_TDWB1: if (MEM_REQ_OUT && MEM_ACK_IN) begin
          state_ff <= retire_ff ? usbls_pkg::S_TDLINK : usbls_pkg::S_NEXT;
        end
        usbls_pkg::S_TDLINK: if (MEM_REQ_OUT && MEM_ACK_IN) begin
          done_head_ff <= td_ptr_ff;
          state_ff <= usbls_pkg::S_EDWB;
        end
        usbls_pkg::S_EDWB: if (MEM_REQ_OUT && MEM_ACK_IN) state_ff <= usbls_pkg::S_NEXT;
        usbls_pkg::S_NEXT: begin
          if (per_ff) begin
            ed_ptr_ff <= ed_next;
            per_done_ff <= (ed_next == 32'h0);
            state_ff <= (ed_next == 32'h0) ? usbls_pkg::S_NPSEL : usbls_pkg::S_EDRD;
          end else begin
            if (sel_ctrl_ff) ctrl_cur_ff <= ed_next;
            else bulk_cur_ff <= ed_next;
            state_ff <= usbls_pkg::S_NPSEL;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bit enable for the active speed
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      BIT_EN_OUT <= 1'b0;
    end else begin
      BIT_EN_OUT <= TXN_LS_OUT ? fi.ls_tick : fi.fs_tick;
    end
  end

endmodule
